// file: rtl/sts_top.sv
// Sampling trigger sequencer with AXI4-Lite register slave
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "sts_cfg.svh"
module sts_top import sts_pkg::*; #(
  parameter int AI_DW = `STS_AI_DW,
  parameter int AO_DW = `STS_AO_DW
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Input side pins
  input wire logic ai_ext_start,
  input wire logic ai_ext_stop,
  input wire logic ai_ext_clk,
  input wire logic ai_cmp_hit,
  input wire logic ai_evt_start,
  input wire logic ai_evt_stop,
  output logic ai_conv,
  output logic [4:0] ai_chan,
  output logic [1:0] ai_status,
  // Output side pins
  input wire logic ao_ext_start,
  input wire logic ao_ext_stop,
  input wire logic ao_ext_clk,
  input wire logic ao_evt_start,
  input wire logic ao_evt_stop,
  output logic ao_conv,
  output logic [1:0] ao_status
);
  // Offsets that answer OKAY
  function automatic logic mapped(logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= `STS_AO_PUSH);
  endfunction

  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] ai_cfg_q, ao_cfg_q, ai_lim_q, ao_lim_q;
  logic [15:0] ai_per_q, ao_per_q;
  logic [5:0] ctl_q;
  logic ai_pop_q, ao_push_q;
  logic [4:0] chan_q;
  logic [AI_DW:0] ai_lvl;
  logic [AO_DW:0] ao_lvl;
  logic ai_lost, ao_lost;
  logic [31:0] rd_mux;

  // Address and data are captured independently; the response waits for both
  wire aw_hs = awvalid & awready;
  wire w_hs = wvalid & wready;
  wire ar_hs = arvalid & arready;
  wire wr_go = aw_full_q & w_full_q & ~bvalid_q;
  wire wr_ok = mapped(aw_addr_q);
  assign awready = ~aw_full_q;
  assign wready = ~w_full_q;
  assign arready = ~rvalid_q;

  // Write strobes per register
  wire wr_ctrl = wr_go & (aw_addr_q == `STS_CTRL);
  wire wr_ai_cfg = wr_go & (aw_addr_q == `STS_AI_CFG);
  wire wr_ao_cfg = wr_go & (aw_addr_q == `STS_AO_CFG);
  wire wr_ai_lim = wr_go & (aw_addr_q == `STS_AI_LIM);
  wire wr_ao_lim = wr_go & (aw_addr_q == `STS_AO_LIM);
  wire wr_ai_per = wr_go & (aw_addr_q == `STS_AI_PER);
  wire wr_ao_per = wr_go & (aw_addr_q == `STS_AO_PER);
  wire wr_ai_pop = wr_go & (aw_addr_q == `STS_AI_POP);
  wire wr_ao_push = wr_go & (aw_addr_q == `STS_AO_PUSH);
  wire [31:0] w_merged = sts_wmerge(32'h0, w_data_q, w_strb_q);
  // Period writes merge into a zero-extended copy, then keep 16 bits
  wire [31:0] ai_per_m = sts_wmerge({16'h0, ai_per_q}, w_data_q, w_strb_q);
  wire [31:0] ao_per_m = sts_wmerge({16'h0, ao_per_q}, w_data_q, w_strb_q);

  // Bus channel state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
    end else begin
      if (aw_hs) aw_addr_q <= awaddr;
      if (w_hs) w_data_q <= wdata;
      if (w_hs) w_strb_q <= wstrb;
      aw_full_q <= (aw_full_q & ~wr_go) | aw_hs;
      w_full_q <= (w_full_q & ~wr_go) | w_hs;
      bvalid_q <= (bvalid_q & ~bready) | wr_go;
      if (wr_go) bresp_q <= wr_ok ? 2'h0 : 2'h2;
    end
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= 2'h0;
    end else begin
      rvalid_q <= (rvalid_q & ~rready) | ar_hs;
      if (ar_hs) rdata_q <= mapped(araddr) ? rd_mux : 32'h0;
      if (ar_hs) rresp_q <= mapped(araddr) ? 2'h0 : 2'h2;
    end
  end
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // Configuration registers; writes obey the byte strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ai_cfg_q <= `STS_CFG_RST;
      ao_cfg_q <= `STS_CFG_RST;
      ai_lim_q <= `STS_LIM_RST;
      ao_lim_q <= `STS_LIM_RST;
      ai_per_q <= `STS_PER_RST;
      ao_per_q <= `STS_PER_RST;
    end else begin
      if (wr_ai_cfg)
        ai_cfg_q <= sts_wmerge(ai_cfg_q, w_data_q, w_strb_q) & `STS_CFG_MASK;
      if (wr_ao_cfg)
        ao_cfg_q <= sts_wmerge(ao_cfg_q, w_data_q, w_strb_q) & `STS_CFG_MASK;
      if (wr_ai_lim) ai_lim_q <= sts_wmerge(ai_lim_q, w_data_q, w_strb_q);
      if (wr_ao_lim) ao_lim_q <= sts_wmerge(ao_lim_q, w_data_q, w_strb_q);
      if (wr_ai_per) ai_per_q <= ai_per_m[15:0];
      if (wr_ao_per) ao_per_q <= ao_per_m[15:0];
    end
  end

  // Command pulses: one cycle each, reading back as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_q <= 6'h00;
      ai_pop_q <= 1'b0;
      ao_push_q <= 1'b0;
    end else begin
      ctl_q <= wr_ctrl ? w_merged[5:0] : 6'h00;
      ai_pop_q <= wr_ai_pop;
      ao_push_q <= wr_ao_push;
    end
  end

  // Sequencer configuration
  sts_seq_if ai_if ();
  sts_seq_if ao_if ();
  assign ai_if.start_src = sts_start_e'(ai_cfg_q[`STS_F_START +: 2]);
  assign ai_if.stop_src = sts_stop_e'(ai_cfg_q[`STS_F_STOP +: 3]);
  assign ai_if.sel0 = sts_stsel_e'(ai_cfg_q[`STS_F_SEL0 +: 2]);
  assign ai_if.sel1 = sts_stsel_e'(ai_cfg_q[`STS_F_SEL1 +: 2]);
  assign ai_if.start_fall = ai_cfg_q[`STS_F_START_FALL];
  assign ai_if.stop_fall = ai_cfg_q[`STS_F_STOP_FALL];
  assign ai_if.clk_fall = ai_cfg_q[`STS_F_CLK_FALL];
  assign ai_if.clk_ext = ai_cfg_q[`STS_F_CLK_EXT];
  assign ai_if.period = ai_per_q;
  assign ai_if.limit = ai_lim_q;
  assign ai_if.sw_start = ctl_q[`STS_GO_AI];
  assign ai_if.sw_stop = ctl_q[`STS_HALT_AI];
  assign ao_if.start_src = sts_start_e'(ao_cfg_q[`STS_F_START +: 2]);
  assign ao_if.stop_src = sts_stop_e'(ao_cfg_q[`STS_F_STOP +: 3]);
  assign ao_if.sel0 = sts_stsel_e'(ao_cfg_q[`STS_F_SEL0 +: 2]);
  assign ao_if.sel1 = sts_stsel_e'(ao_cfg_q[`STS_F_SEL1 +: 2]);
  assign ao_if.start_fall = ao_cfg_q[`STS_F_START_FALL];
  assign ao_if.stop_fall = ao_cfg_q[`STS_F_STOP_FALL];
  assign ao_if.clk_fall = ao_cfg_q[`STS_F_CLK_FALL];
  assign ao_if.clk_ext = ao_cfg_q[`STS_F_CLK_EXT];
  assign ao_if.period = ao_per_q;
  assign ao_if.limit = ao_lim_q;
  assign ao_if.sw_start = ctl_q[`STS_GO_AO];
  assign ao_if.sw_stop = ctl_q[`STS_HALT_AO];

  // Input sequencer
  sts_seq #(.HAS_CMP(1'b1)) u_ai_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .cf(ai_if.seq),
    .ext_start(ai_ext_start),
    .ext_stop(ai_ext_stop),
    .ext_clk(ai_ext_clk),
    .cmp_hit(ai_cmp_hit),
    .evt_start(ai_evt_start),
    .evt_stop(ai_evt_stop)
  );

  // Output sequencer; it has no compare source
  sts_seq #(.HAS_CMP(1'b0)) u_ao_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .cf(ao_if.seq),
    .ext_start(ao_ext_start),
    .ext_stop(ao_ext_stop),
    .ext_clk(ao_ext_clk),
    .cmp_hit(1'b0),
    .evt_start(ao_evt_start),
    .evt_stop(ao_evt_stop)
  );

  // Input buffer gets one word per converted channel
  sts_bufctl #(.DW(AI_DW), .REPLAY(1'b0)) u_ai_buf (
    .aclk(aclk),
    .aresetn(aresetn),
    .push(ai_if.tick),
    .pop(ai_pop_q),
    .clear(ctl_q[`STS_CLR_AI]),
    .ring(ai_cfg_q[`STS_F_RING]),
    .level(ai_lvl),
    .lost(ai_lost)
  );

  // Output buffer is loaded by software and, in FIFO mode, drained per generated sample
  sts_bufctl #(.DW(AO_DW), .REPLAY(1'b1)) u_ao_buf (
    .aclk(aclk),
    .aresetn(aresetn),
    .push(ao_push_q),
    .pop(ao_if.tick),
    .clear(ctl_q[`STS_CLR_AO]),
    .ring(ao_cfg_q[`STS_F_RING]),
    .level(ao_lvl),
    .lost(ao_lost)
  );

  // Scan limit: fewer channels exist in differential wiring
  wire diff = ai_cfg_q[`STS_F_DIFF];
  wire [4:0] nch = ai_cfg_q[`STS_F_NCH +: 5];
  wire [4:0] hw_last = diff ? `STS_DIFF_LAST : `STS_SE_LAST;
  wire [4:0] scan_last = (nch > hw_last) ? hw_last : nch;
  wire scan_wrap = (chan_q >= scan_last);

  // Channel scan restarts at zero with each start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_q <= 5'h00;
    end else if (!ai_if.running) begin
      chan_q <= 5'h00;
    end else if (ai_if.tick) begin
      chan_q <= scan_wrap ? 5'h00 : chan_q + 5'h01;
    end
  end

  // Read selection
  wire [31:0] status_w = {19'h0, chan_q, 2'h0, ao_lost, ai_lost,
                          (ao_lvl == '0), ao_lvl[AO_DW], ai_if.running & 1'b1,
                          ao_if.running};
  assign rd_mux =
    (araddr == `STS_AI_CFG) ? ai_cfg_q :
    (araddr == `STS_AO_CFG) ? ao_cfg_q :
    (araddr == `STS_AI_LIM) ? ai_lim_q :
    (araddr == `STS_AO_LIM) ? ao_lim_q :
    (araddr == `STS_AI_PER) ? {16'h0, ai_per_q} :
    (araddr == `STS_AO_PER) ? {16'h0, ao_per_q} :
    (araddr == `STS_STATUS) ? status_w :
    (araddr == `STS_AI_LVL) ? 32'(ai_lvl) :
    (araddr == `STS_AO_LVL) ? 32'(ao_lvl) : 32'h0;

  // Pin outputs, all from flip-flops: sequencer tick and status, and the scan counter chan_q for the channel
  assign ai_conv = ai_if.tick;
  assign ai_chan = chan_q;
  assign ai_status = ai_if.st;
  assign ao_conv = ao_if.tick;
  assign ao_status = ao_if.st;

  // Checks
  a_scan_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    (ai_if.running && ai_if.tick && chan_q == hw_last && !$rose(diff))
    |=> chan_q == 5'h00) else $error("Scan passed the last channel");
  a_idle_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ai_if.running && !ai_pop_q && !ctl_q[`STS_CLR_AI]) |=> $stable(ai_lvl))
    else $error("Idle input buffer changed");
  a_ao_status: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(ao_if.sel1) == SS_CLK |-> ao_status[1] == ao_conv)
    else $error("Output status pin not showing clock");
  c_write_resp: cover property (@(posedge aclk) bvalid && bready);
endmodule // sts_top

// file: rtl/sts_cfg.svh
// Register map, field positions, reset values and timing counts
// Behaviour
// - Input side starts on software, data compare, start pin or event.
// - Input side stops on save done, compare, stop pin, event or software.
// - Output sequencer starts on software, start pin or event output.
// - Output side stops on last sample count, stop pin, event or software.
// - Start, stop and clock pins are each sensed on a chosen edge.
// - Input buffer runs as FIFO or overwriting ring of 128M words.
// - Output buffer runs as FIFO or repeating ring of 256k words.
// - Input scan covers 32 single-ended or 16 differential channels.
// - Input side drives two chosen status pins, sampling clock among them.
// - Output side drives two chosen status pins, generation clock among them.
`ifndef STS_CFG_SVH
`define STS_CFG_SVH
`define STS_CTRL 8'h00
`define STS_AI_CFG 8'h04
`define STS_AO_CFG 8'h08
`define STS_AI_LIM 8'h0c
`define STS_AO_LIM 8'h10
`define STS_AI_PER 8'h14
`define STS_AO_PER 8'h18
`define STS_STATUS 8'h1c
`define STS_AI_LVL 8'h20
`define STS_AO_LVL 8'h24
`define STS_AI_POP 8'h28
`define STS_AO_PUSH 8'h2c
`define STS_GO_AI 0
`define STS_HALT_AI 1
`define STS_GO_AO 2
`define STS_HALT_AO 3
`define STS_CLR_AI 4
`define STS_CLR_AO 5
`define STS_F_START 0
`define STS_F_STOP 2
`define STS_F_START_FALL 5
`define STS_F_STOP_FALL 6
`define STS_F_CLK_FALL 7
`define STS_F_CLK_EXT 8
`define STS_F_RING 9
`define STS_F_DIFF 10
`define STS_F_NCH 11
`define STS_F_SEL0 16
`define STS_F_SEL1 18
`define STS_CFG_MASK 32'h000f_ffff
`define STS_CFG_RST 32'h0000_0000
`define STS_LIM_RST 32'h0000_0000
`define STS_CLK_NS 50
`define STS_CONV_NS 10000
`define STS_PER_RST 16'((`STS_CONV_NS + `STS_CLK_NS - 1) / `STS_CLK_NS)
`define STS_AI_DW 27
`define STS_AO_DW 18
`define STS_SE_LAST 5'h1f
`define STS_DIFF_LAST 5'h0f
`endif

// file: rtl/sts_pkg.sv
// Types shared by the sampling trigger sequencer
package sts_pkg;
  typedef enum logic [1:0] {
    ST_SW = 2'h0, ST_CMP = 2'h1, ST_EXT = 2'h2, ST_EVT = 2'h3
  } sts_start_e;
  typedef enum logic [2:0] {
    SP_CNT = 3'h0, SP_CMP = 3'h1, SP_EXT = 3'h2, SP_EVT = 3'h3, SP_SW = 3'h4
  } sts_stop_e;
  typedef enum logic [1:0] {
    SS_CLK = 2'h0, SS_RUN = 2'h1, SS_START = 2'h2, SS_STOP = 2'h3
  } sts_stsel_e;
  typedef enum logic {S_IDLE = 1'b0, S_RUN = 1'b1} sts_run_e;
  // Edge of a pin against its previous sample
  function automatic logic sts_edge(logic prev, logic cur, logic fall);
    return fall ? (prev & ~cur) : (~prev & cur);
  endfunction
  // Status pin source selection
  function automatic logic sts_stmux(sts_stsel_e s, logic [3:0] src);
    return src[s];
  endfunction
  // Byte-lane merge of a bus write
  function automatic logic [31:0] sts_wmerge(logic [31:0] o, logic [31:0] n,
                                            logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      if (st[i]) o[8*i +: 8] = n[8*i +: 8];
    end
    return o;
  endfunction
endpackage

// file: rtl/sts_seq_if.sv
// Configuration and state between register block and one sequencer
`timescale 1ns/1ps
interface sts_seq_if;
  import sts_pkg::*;
  sts_start_e start_src;
  sts_stop_e stop_src;
  sts_stsel_e sel0;
  sts_stsel_e sel1;
  logic start_fall;
  logic stop_fall;
  logic clk_fall;
  logic clk_ext;
  logic [15:0] period;
  logic [31:0] limit;
  logic sw_start;
  logic sw_stop;
  logic running;
  logic tick;
  logic [1:0] st;
  modport regs(output start_src, stop_src, sel0, sel1, start_fall, stop_fall,
               clk_fall, clk_ext, period, limit, sw_start, sw_stop,
               input running, tick, st);
  modport seq(input start_src, stop_src, sel0, sel1, start_fall, stop_fall,
              clk_fall, clk_ext, period, limit, sw_start, sw_stop,
              output running, tick, st);
endinterface

// file: rtl/sts_seq.sv
// One start/stop sequencer with pacer, edge select and status pins
`timescale 1ns/1ps
module sts_seq import sts_pkg::*; #(
  parameter bit HAS_CMP = 1'b1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register side
  sts_seq_if.seq cf,
  // Trigger and clock sources
  input wire logic ext_start,
  input wire logic ext_stop,
  input wire logic ext_clk,
  input wire logic cmp_hit,
  input wire logic evt_start,
  input wire logic evt_stop
);
  sts_run_e state_q, state_d;
  logic [2:0] prev_q;
  logic [15:0] pace_q;
  logic [31:0] cnt_q;
  logic tick_q;
  logic [1:0] st_q;
  logic start_hit, stop_hit, tick_d;
  // Pin edges on the configured polarity
  wire start_edge = sts_edge(prev_q[0], ext_start, cf.start_fall);
  wire stop_edge = sts_edge(prev_q[1], ext_stop, cf.stop_fall);
  wire clk_edge = sts_edge(prev_q[2], ext_clk, cf.clk_fall);
  wire running = (state_q == S_RUN);
  wire cnt_done = (cf.limit != 32'h0) && (cnt_q == cf.limit);
  wire pace_wrap = ({1'b0, pace_q} + 17'h1) >= {1'b0, cf.period};
  // Source selection; compare is absent on the output side
  assign start_hit = (cf.start_src == ST_SW) ? cf.sw_start :
    (cf.start_src == ST_CMP) ? (HAS_CMP & cmp_hit) :
    (cf.start_src == ST_EXT) ? start_edge : evt_start;
  assign stop_hit = (cf.stop_src == SP_CNT) ? cnt_done :
    (cf.stop_src == SP_CMP) ? (HAS_CMP & cmp_hit) :
    (cf.stop_src == SP_EXT) ? stop_edge :
    (cf.stop_src == SP_EVT) ? evt_stop :
    (cf.stop_src == SP_SW) ? cf.sw_stop : 1'b0;
  // No clock while idle or in the stopping cycle
  assign tick_d = running & ~stop_hit & (cf.clk_ext ? clk_edge : pace_wrap);
  // Run state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE: if (start_hit) state_d = S_RUN;
      S_RUN: if (stop_hit) state_d = S_IDLE;
    endcase
  end
  // Counters and registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_IDLE;
      prev_q <= 3'h0;
      pace_q <= 16'h0;
      cnt_q <= 32'h0;
      tick_q <= 1'b0;
      st_q <= 2'h0;
    end else begin
      state_q <= state_d;
      prev_q <= {ext_clk, ext_stop, ext_start};
      pace_q <= (!running || pace_wrap) ? 16'h0 : pace_q + 16'h1;
      cnt_q <= running ? cnt_q + {31'h0, tick_d} : 32'h0;
      tick_q <= tick_d;
      st_q[0] <= sts_stmux(cf.sel0, {stop_hit, start_hit, running, tick_d});
      st_q[1] <= sts_stmux(cf.sel1, {stop_hit, start_hit, running, tick_d});
    end
  end
  assign cf.running = running;
  assign cf.tick = tick_q;
  assign cf.st = st_q;
  // Checks
  a_idle_no_tick: assert property (@(posedge aclk) disable iff (!aresetn)
    !running |=> !tick_q) else $error("Conversion clock while idle");
  a_sw_start: assert property (@(posedge aclk) disable iff (!aresetn)
    (!running && cf.start_src == ST_SW && cf.sw_start) |=> running)
    else $error("Software start ignored");
  a_ext_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    (running && cf.stop_src == SP_EXT && cf.stop_fall && $fell(ext_stop))
    |=> !running ##1 !tick_q) else $error("Falling stop edge ignored");
  a_cnt_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    (running && cf.stop_src == SP_CNT && cnt_done) |=> !running)
    else $error("Sample count did not stop");
  a_st_clock: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(cf.sel0) == SS_CLK |-> st_q[0] == tick_q)
    else $error("Status pin not showing clock");
  c_start: cover property (@(posedge aclk) !running ##1 running);
  c_cnt_stop: cover property (@(posedge aclk) running && cnt_done);
endmodule // sts_seq

// file: rtl/sts_bufctl.sv
// Occupancy tracking of one sample buffer, FIFO or ring
`timescale 1ns/1ps
module sts_bufctl import sts_pkg::*; #(
  parameter int DW = 18,
  parameter bit REPLAY = 1'b0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Word events
  input wire logic push,
  input wire logic pop,
  input wire logic clear,
  input wire logic ring,
  // State
  output logic [DW:0] level,
  output logic lost
);
  logic [DW:0] lvl_q;
  logic lost_q;
  wire full = lvl_q[DW];
  wire empty = (lvl_q == '0);
  // A replaying ring keeps its words; an overwriting ring keeps its level
  wire do_pop = pop & ~empty & ~(REPLAY & ring);
  wire do_push = push & ~full;
  wire overrun = push & full & ~ring;
  wire [DW:0] lvl_d = (clear ? '0 : lvl_q - {{DW{1'b0}}, do_pop})
                      + {{DW{1'b0}}, do_push};
  // Level and overrun flag; a new overrun wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl_q <= '0;
      lost_q <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
      lost_q <= (lost_q & ~clear) | overrun;
    end
  end
  assign level = lvl_q;
  assign lost = lost_q;
  a_fifo_refuse: assert property (@(posedge aclk) disable iff (!aresetn)
    (push && full && !ring && !pop && !clear) |=> (lvl_q[DW] && lost_q))
    else $error("Full FIFO accepted a word");
  a_ring_replay: assert property (@(posedge aclk) disable iff (!aresetn)
    (REPLAY && ring && pop && !push && !clear) |=> $stable(lvl_q))
    else $error("Replaying ring lost a word");
  c_ring_wrap: cover property (@(posedge aclk) push && full && ring);
endmodule // sts_bufctl

// file: test/sts_ext_model.sv
// External trigger logic model: start, stop and clock pins
`timescale 1ns/1ps
module sts_ext_model (
  // Clock
  input wire logic aclk,
  // Pins: 0 start, 1 stop, 2 clock
  output logic [2:0] pin
);
  initial pin = 3'h0;
  // Park a pin at a level; with fall set this is the rest level
  task automatic rest(input int k, input logic fall);
    @(posedge aclk);
    pin[k] <= fall;
    repeat (4) @(posedge aclk);
  endtask
  // One event on the configured edge, held long enough to be sampled
  task automatic fire(input int k, input logic fall);
    @(posedge aclk);
    pin[k] <= ~fall;
    repeat (2) @(posedge aclk);
    pin[k] <= fall;
    repeat (2) @(posedge aclk);
  endtask
endmodule // sts_ext_model

// file: test/testbench.sv
// Self-checking bench of the sampling trigger sequencer
`timescale 1ns/1ps
`include "sts_cfg.svh"
module testbench import sts_pkg::*;;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, ai_conv, ao_conv;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, ai_status, ao_status;
  logic [4:0] ai_chan, chmax;
  logic [2:0] aip, aop, trg;
  int err_count = 0, samples_checked = 0;
  int ai_n = 0, ao_n = 0, cyc_n = 0, ai_last = 0, ai_gap = 0;
  sts_ext_model ai_x (.aclk(aclk), .pin(aip));
  sts_ext_model ao_x (.aclk(aclk), .pin(aop));
  // Event start, compare hit and event stop come from trg bits 0, 1, 2
  sts_top dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .ai_ext_start(aip[0]), .ai_ext_stop(aip[1]), .ai_ext_clk(aip[2]),
    .ai_cmp_hit(trg[1]), .ai_evt_start(trg[0]), .ai_evt_stop(trg[2]),
    .ai_conv(ai_conv), .ai_chan(ai_chan), .ai_status(ai_status),
    .ao_ext_start(aop[0]), .ao_ext_stop(aop[1]), .ao_ext_clk(aop[2]),
    .ao_evt_start(trg[0]), .ao_evt_stop(trg[2]), .ao_conv(ao_conv),
    .ao_status(ao_status));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Count pulses and the spacing of the last two input conversions
  always @(posedge aclk) begin
    cyc_n++;
    if (ai_conv === 1'b1) begin
      ai_gap = cyc_n - ai_last;
      ai_last = cyc_n;
      ai_n++;
      if (ai_chan > chmax) chmax = ai_chan;
    end
    if (ao_conv === 1'b1) ao_n++;
  end
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task hang;
    $display("MISMATCH bus_wait expected 1 seen 0");
    err_count++;
    summarize();
  endtask
  // Waits end on a falling edge so that sampled outputs are settled
  task cyc(input int n);
    repeat (n) @(negedge aclk);
  endtask
  // Write: both channels offered together, released when each is taken
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(negedge aclk);
      ta = awready & awvalid;
      tw = wready & wvalid;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) break;
    end
    bready <= 1'b0;
    if (i == 64) hang();
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    logic ta, tb;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(negedge aclk);
      ta = arready & arvalid;
      tb = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tb) break;
    end
    rready <= 1'b0;
    if (i == 64) hang();
  endtask
  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, e, d);
  endtask
  // Reset values and an unmapped offset in both directions
  task sc_bus;
    logic [31:0] d;
    logic [1:0] r;
    rchk("ai_per rst", `STS_AI_PER, 32'(`STS_PER_RST));
    rchk("ao_cfg rst", `STS_AO_CFG, 32'h0);
    rd(8'h30, d, r);
    chk("bad rd resp", 32'h2, 32'(r));
    chk("bad rd data", 32'h0, d);
    wr(8'h30, 32'hffff_ffff, r);
    chk("bad wr resp", 32'h2, 32'(r));
  endtask
  // Software start and stop with the pacer; buffer keeps its words
  task sc_sw_run;
    logic [31:0] d;
    logic [1:0] r;
    int n, m;
    wr(`STS_AI_PER, 32'h4, r);
    wr(`STS_AI_CFG, (32'h4 << `STS_F_STOP) | (32'h1 << `STS_F_SEL0), r);
    wr(`STS_CTRL, 32'h1 << `STS_CLR_AI, r);
    n = ai_n;
    wr(`STS_CTRL, 32'h1 << `STS_GO_AI, r);
    cyc(30);
    chk("ai status run", 32'h1, 32'(ai_status[0]));
    wr(`STS_CTRL, 32'h1 << `STS_HALT_AI, r);
    cyc(3);
    m = ai_n;
    cyc(20);
    chk("ai idle conv", m, ai_n);
    chk("ai started", 32'h1, 32'(m > n));
    chk("ai pacer gap", 32'h4, ai_gap);
    rd(`STS_STATUS, d, r);
    chk("ai halted", 32'h0, 32'(d[1]));
    rchk("ai level", `STS_AI_LVL, m - n);
    wr(`STS_AI_POP, 32'h0, r);
    rchk("ai level pop", `STS_AI_LVL, m - n - 1);
  endtask
  // One-cycle pulse on an event or compare input
  task pulse(input int k);
    @(posedge aclk);
    trg[k] <= 1'b1;
    @(posedge aclk);
    trg[k] <= 1'b0;
  endtask
  // Event start and compare stop on the input side
  task sc_evt;
    logic [31:0] d;
    logic [1:0] r;
    wr(`STS_AI_CFG, 32'h3 | (32'h1 << `STS_F_STOP), r);
    pulse(0);
    rd(`STS_STATUS, d, r);
    chk("ai evt start", 32'h1, 32'(d[1]));
    pulse(1);
    rd(`STS_STATUS, d, r);
    chk("ai cmp stop", 32'h0, 32'(d[1]));
  endtask
  // Pin start, falling clock, differential scan wrap and falling pin stop
  task sc_ext;
    logic [1:0] r;
    int n;
    ai_x.rest(0, 1'b1);
    ai_x.rest(2, 1'b1);
    ai_x.rest(1, 1'b1);
    wr(`STS_AI_CFG, 32'h2 | (32'h2 << `STS_F_STOP) |
       (32'h1 << `STS_F_START_FALL) | (32'h1 << `STS_F_STOP_FALL) |
       (32'h1 << `STS_F_CLK_FALL) |
       (32'h1 << `STS_F_CLK_EXT) | (32'h1 << `STS_F_DIFF) |
       (32'h1f << `STS_F_NCH), r);
    n = ai_n;
    ai_x.fire(2, 1'b1);
    cyc(3);
    chk("ai clk idle", n, ai_n);
    ai_x.fire(0, 1'b1);
    cyc(3);
    chmax = 5'h0;
    for (int i = 0; i < 20; i++) ai_x.fire(2, 1'b1);
    cyc(3);
    chk("ai ext clk", n + 20, ai_n);
    chk("ai chan wrap", 32'h0f, 32'(chmax));
    ai_x.rest(2, 1'b0);
    cyc(3);
    chk("ai fall edge", n + 21, ai_n);
    ai_x.rest(2, 1'b1);
    cyc(3);
    chk("ai rise ignored", n + 21, ai_n);
    ai_x.fire(1, 1'b1);
    cyc(3);
    n = ai_n;
    ai_x.fire(2, 1'b1);
    cyc(3);
    chk("ai pin stop", n, ai_n);
  endtask
  // Output side: count stop in FIFO, then pin start in repeating ring
  task sc_ao;
    logic [1:0] r;
    int n;
    wr(`STS_AO_PER, 32'h3, r);
    wr(`STS_AO_LIM, 32'h3, r);
    wr(`STS_AO_CFG, 32'h1 << `STS_F_SEL1, r);
    wr(`STS_CTRL, 32'h1 << `STS_CLR_AO, r);
    for (int i = 0; i < 3; i++) wr(`STS_AO_PUSH, i, r);
    n = ao_n;
    wr(`STS_CTRL, 32'h1 << `STS_GO_AO, r);
    cyc(4);
    chk("ao status run", 32'h1, 32'(ao_status[1]));
    cyc(30);
    chk("ao count stop", n + 3, ao_n);
    rchk("ao fifo level", `STS_AO_LVL, 32'h0);
    wr(`STS_AO_CFG, 32'h2 | (32'h1 << `STS_F_RING), r);
    for (int i = 0; i < 2; i++) wr(`STS_AO_PUSH, i, r);
    ao_x.fire(0, 1'b0);
    cyc(30);
    chk("ao pin start", n + 6, ao_n);
    rchk("ao ring level", `STS_AO_LVL, 32'h2);
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hf;
    trg = 3'h0;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    sc_bus();
    sc_sw_run();
    sc_evt();
    sc_ext();
    sc_ao();
    summarize();
  end
endmodule // testbench
